//--- design/osr_pkg.sv
// Shared constants, types and carriers for the OTP security register unit.
package osr_pkg;

   // Data bus width and offset decode width.
   localparam int DATA_W = 16;
   localparam int OFF_W = 9;
   localparam int SR_W = 8;

   // Command codes accepted on the write strobe.
   localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
   localparam logic [7:0] CMD_READ_ID = 8'h90;
   localparam logic [7:0] CMD_READ_STATUS = 8'h70;
   localparam logic [7:0] CMD_PROG_OTP = 8'hC0;

   // Identifier-space offsets of the lock words and register words.
   localparam logic [OFF_W-1:0] OFF_LOCK0 = 9'h080;
   localparam logic [OFF_W-1:0] OFF_FACT_LO = 9'h081;
   localparam logic [OFF_W-1:0] OFF_FACT_HI = 9'h084;
   localparam logic [OFF_W-1:0] OFF_USER_LO = 9'h085;
   localparam logic [OFF_W-1:0] OFF_USER_HI = 9'h088;
   localparam logic [OFF_W-1:0] OFF_LOCK1 = 9'h089;
   localparam logic [OFF_W-1:0] OFF_UP_LO = 9'h08A;
   localparam logic [OFF_W-1:0] OFF_UP_HI = 9'h109;

   // Register organisation: one split register plus sixteen upper ones.
   localparam int NUM_REGS = 17;
   localparam int UP_REGS = 16;
   localparam int USER0_WORDS = 4;
   localparam int MEM_WORDS = 132;
   localparam int MEM_AW = 8;
   localparam logic [MEM_AW-1:0] USER0_BASE = 8'h04;

   // Lock word reset values; a programmed lock bit reads as zero.
   localparam logic [DATA_W-1:0] LOCK0_RESET = 16'hFFFE;
   localparam logic [DATA_W-1:0] LOCK1_RESET = 16'hFFFF;
   localparam int LOCK0_FACT_BIT = 0;
   localparam int LOCK0_USER_BIT = 1;

   // Status word bit positions.
   localparam int SR_READY_BIT = 7;
   localparam int SR_PFAIL_BIT = 4;
   localparam int SR_LOCK_BIT = 1;
   localparam logic [7:0] SR_HI_BYTE = 8'h00;

   // Fill words for undefined page words and unmapped identifier offsets.
   localparam logic [DATA_W-1:0] UNDEF_WORD = 16'hFFFF;
   localparam logic [DATA_W-1:0] NOID_WORD = 16'h0000;
   localparam logic [DATA_W-1:0] BLANK_WORD = 16'hFFFF;

   // Selectable OTP area block numbers.
   localparam int BLK_W = 9;
   localparam logic [BLK_W-1:0] PTOP_256 = 9'h102;
   localparam logic [BLK_W-1:0] PTOP_128 = 9'h082;
   localparam logic [BLK_W-1:0] PTOP_64 = 9'h042;
   localparam logic [BLK_W-1:0] PBOT_HI = 9'h003;
   localparam logic [BLK_W-1:0] PARAM_SPAN = 9'h003;
   localparam int MAIN_AREAS = 3;
   localparam int OTP_AREAS = 4;

   // Burst length codes and beat counts.
   localparam logic [1:0] BL_CONT = 2'h3;
   localparam logic [4:0] BEATS_4 = 5'h04;
   localparam logic [4:0] BEATS_8 = 5'h08;
   localparam logic [4:0] BEATS_16 = 5'h10;
   localparam logic [4:0] BEATS_1 = 5'h01;
   localparam int PIDX_W = 2;

   // Word program duration in clock cycles.
   localparam logic [7:0] PROG_CYCLES = 8'h10;

   // Read timing modes, output states and write machine states.
   typedef enum logic [1:0] {RDM_ASYNC, RDM_PAGE, RDM_BURST} osr_rdm_t;
   typedef enum logic [1:0] {RS_ARRAY, RS_ID, RS_STATUS} osr_rstate_t;
   typedef enum logic [1:0] {W_IDLE, W_SETUP, W_PROG} osr_wsm_t;

   // Latched program request and latched read request.
   typedef struct packed {
      logic [OFF_W-1:0] off;
      logic [DATA_W-1:0] data;
   } osr_preq_t;

   typedef struct packed {
      logic [OFF_W-1:0] off;
      logic [PIDX_W-1:0] pidx;
      osr_rdm_t mode;
      osr_rstate_t rstate;
   } osr_rreq_t;

endpackage : osr_pkg

//--- design/osr_word_mem.sv
// Word store for the user OTP register words with a registered read port.
`timescale 1ns/100ps
module osr_word_mem
   import osr_pkg::*;
#(
   parameter int DW = DATA_W,
   parameter int DEPTH = MEM_WORDS,
   parameter int AW = MEM_AW
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic resetn,
   // Write port; a write can only clear bits.
   input wire logic we,
   input wire logic [AW-1:0] waddr,
   input wire logic [DW-1:0] wdata,
   // Read port.
   input wire logic [AW-1:0] raddr,
   output logic [DW-1:0] rdata
);

   logic [DW-1:0] mem_q [DEPTH];

   // Cells start blank and a program only turns ones to zeros.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         for (int i = 0; i < DEPTH; i++) begin
            mem_q[i] <= BLANK_WORD;
         end
      end else if (we) begin
         mem_q[waddr] <= mem_q[waddr] & wdata;
      end
   end

   // Read data comes out of a register.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rdata <= BLANK_WORD;
      end else begin
         rdata <= mem_q[raddr];
      end
   end

endmodule : osr_word_mem

//--- design/osr_otp_security.sv
// OTP security registers, lock words, OTP block areas and non-array reads.
`timescale 1ns/100ps
module osr_otp_security
   import osr_pkg::*;
#(
   parameter int ADDR_W = 24,
   parameter logic [BLK_W-1:0] PARAM_TOP_BLK = PTOP_256,
   parameter bit TOP_PARAM = 1'b1,
   parameter logic [7:0] PROG_LEN = PROG_CYCLES,
   // Arbitrary unique number standing in for the factory-written half.
   parameter logic [63:0] FACTORY_UID = 64'h0123456789ABCDEF
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic resetn,
   // Parallel bus: command and data writes.
   input wire logic bus_wr,
   input wire logic [ADDR_W-1:0] bus_addr,
   input wire logic [DATA_W-1:0] bus_wdata,
   // Parallel bus: read requests and read data.
   input wire logic bus_rd,
   input wire osr_rdm_t rd_mode,
   input wire logic [1:0] burst_len,
   input wire logic burst_stop,
   input wire logic [DATA_W-1:0] array_rdata,
   output logic [DATA_W-1:0] rd_data,
   output logic rd_valid,
   // Selectable OTP area configuration and block query.
   input wire logic [OTP_AREAS-1:0] otp_area_en,
   input wire logic otp_full_en,
   input wire logic [BLK_W-1:0] query_blk,
   output logic blk_otp
);

   // Offset decode of the bus address and of the latched program address.
   logic [OFF_W-1:0] bus_off;
   logic [OFF_W-1:0] p_off;
   logic p_is_lock0;
   logic p_is_lock1;
   logic p_is_fact;
   logic p_is_user0;
   logic p_is_up;
   logic p_in_range;
   logic p_locked;
   logic [OFF_W-1:0] p_up_diff;
   logic [3:0] p_up_idx;
   logic [MEM_AW-1:0] p_mem_idx;

   // Write machine, read state and status flags.
   osr_wsm_t wsm_q;
   osr_wsm_t wsm_d;
   osr_rstate_t rstate_q;
   osr_preq_t preq_q;
   logic [7:0] pcnt_q;
   logic pfail_q;
   logic lockerr_q;
   logic ready;
   logic [SR_W-1:0] sr_word;

   // Lock words.
   logic [DATA_W-1:0] lock0_q;
   logic [DATA_W-1:0] lock1_q;

   // Read pipeline.
   osr_rreq_t rreq_q;
   logic pend_q;
   logic [DATA_W-1:0] rd_data_q;
   logic rd_valid_q;
   logic [4:0] beats_q;
   logic cont_q;
   logic [4:0] beats_req;

   // Identifier-space decode of the latched read offset.
   logic [OFF_W-1:0] r_off;
   logic r_is_fact;
   logic r_is_user0;
   logic r_is_up;
   logic [1:0] r_fidx;
   logic [DATA_W-1:0] fact_word;
   logic [DATA_W-1:0] id_word;
   logic [DATA_W-1:0] nonarray_word;
   logic [DATA_W-1:0] word_sel;

   // Shared memory port.
   logic mem_we;
   logic [MEM_AW-1:0] mem_raddr;
   logic [MEM_AW-1:0] bus_mem_idx;
   logic [DATA_W-1:0] mem_rdata;
   logic commit;
   logic setup_ok;

   // OTP area decode.
   logic [OTP_AREAS-1:0] area_hit;
   logic [BLK_W-1:0] param_lo;
   logic [BLK_W-1:0] param_hi;
   logic blk_otp_q;

   // Program address decode; every register sits at its identifier offset.
   assign bus_off = bus_addr[OFF_W-1:0];
   assign p_off = preq_q.off;
   assign p_is_lock0 = (p_off == OFF_LOCK0);
   assign p_is_lock1 = (p_off == OFF_LOCK1);
   assign p_is_fact = (p_off >= OFF_FACT_LO) && (p_off <= OFF_FACT_HI);
   assign p_is_user0 = (p_off >= OFF_USER_LO) && (p_off <= OFF_USER_HI);
   assign p_is_up = (p_off >= OFF_UP_LO) && (p_off <= OFF_UP_HI);
   assign p_in_range = p_is_lock0 | p_is_lock1 | p_is_fact | p_is_user0 | p_is_up;
   assign p_up_diff = p_off - OFF_UP_LO;
   assign p_up_idx = p_up_diff[6:3];

   // Lock lookup: factory half, user half, or one of sixteen upper registers.
   assign p_locked = (p_is_fact & ~lock0_q[LOCK0_FACT_BIT])
      | (p_is_user0 & ~lock0_q[LOCK0_USER_BIT])
      | (p_is_up & ~lock1_q[p_up_idx]);

   // Word index into the user store for the program address.
   assign p_mem_idx = p_is_user0 ? MEM_AW'(p_off - OFF_USER_LO)
      : MEM_AW'(p_up_diff + OFF_W'(USER0_WORDS));

   // Word index for a read request taken straight from the bus address.
   assign bus_mem_idx = ((bus_off >= OFF_USER_LO) && (bus_off <= OFF_USER_HI))
      ? MEM_AW'(bus_off - OFF_USER_LO)
      : MEM_AW'(bus_off - OFF_UP_LO + OFF_W'(USER0_WORDS));
   assign mem_raddr = bus_mem_idx;

   // A data write in setup starts a program only when in range and unlocked.
   assign setup_ok = p_in_range & ~p_locked;
   assign commit = (wsm_q == W_PROG) && (pcnt_q == 8'h00);
   assign mem_we = commit & ~p_is_lock0 & ~p_is_lock1;

   // Ready is low only while a word program runs.
   assign ready = (wsm_q != W_PROG);
   assign sr_word = (SR_W'(ready) << SR_READY_BIT) | (SR_W'(pfail_q) << SR_PFAIL_BIT)
      | (SR_W'(lockerr_q) << SR_LOCK_BIT);

   // User store; its write clears bits only, so only reset returns a word to blank.
   osr_word_mem #(
      .DW(DATA_W),
      .DEPTH(MEM_WORDS),
      .AW(MEM_AW)
   ) u_mem (
      .clk(clk),
      .resetn(resetn),
      .we(mem_we),
      .waddr(p_mem_idx),
      .wdata(preq_q.data),
      .raddr(mem_raddr),
      .rdata(mem_rdata)
   );

   // Next state of the write machine.
   always_comb begin
      wsm_d = wsm_q;
      case (wsm_q)
         W_IDLE: begin
            if (bus_wr && (bus_wdata[7:0] == CMD_PROG_OTP)) begin
               wsm_d = W_SETUP;
            end
         end
         W_SETUP: begin
            if (bus_wr) begin
               wsm_d = setup_ok ? W_PROG : W_IDLE;
            end
         end
         W_PROG: begin
            if (pcnt_q == 8'h00) begin
               wsm_d = W_IDLE;
            end
         end
         default: begin
            wsm_d = W_IDLE;
         end
      endcase
   end

   // Write machine state register.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         wsm_q <= W_IDLE;
      end else begin
         wsm_q <= wsm_d;
      end
   end

   // Program request capture; the data word targets the setup address.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         preq_q <= '0;
      end else if (bus_wr && (wsm_q == W_IDLE)) begin
         preq_q.off <= bus_off;
      end else if (bus_wr && (wsm_q == W_SETUP)) begin
         preq_q.data <= bus_wdata;
      end
   end

   // Program duration counter.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         pcnt_q <= 8'h00;
      end else if (bus_wr && (wsm_q == W_SETUP)) begin
         pcnt_q <= PROG_LEN - 8'h01;
      end else if ((wsm_q == W_PROG) && (pcnt_q != 8'h00)) begin
         pcnt_q <= pcnt_q - 8'h01;
      end
   end

   // Error flags are sticky until reset.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         pfail_q <= 1'b0;
         lockerr_q <= 1'b0;
      end else if (bus_wr && (wsm_q == W_SETUP) && !setup_ok) begin
         pfail_q <= 1'b1;
         lockerr_q <= lockerr_q | (p_in_range & p_locked);
      end
   end

   // Lock words only ever lose ones, so only reset can undo a lock.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         lock0_q <= LOCK0_RESET;
         lock1_q <= LOCK1_RESET;
      end else if (commit && p_is_lock0) begin
         lock0_q <= lock0_q & preq_q.data;
      end else if (commit && p_is_lock1) begin
         lock1_q <= lock1_q & preq_q.data;
      end
   end

   // Output state follows read commands; a program switches to status.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rstate_q <= RS_ARRAY;
      end else if (bus_wr && (wsm_q == W_IDLE)) begin
         case (bus_wdata[7:0])
            CMD_READ_ARRAY: rstate_q <= RS_ARRAY;
            CMD_READ_ID: rstate_q <= RS_ID;
            CMD_READ_STATUS: rstate_q <= RS_STATUS;
            CMD_PROG_OTP: rstate_q <= RS_STATUS;
            default: rstate_q <= rstate_q;
         endcase
      end
   end

   // Identifier-space decode of the latched read offset.
   assign r_off = rreq_q.off;
   assign r_is_fact = (r_off >= OFF_FACT_LO) && (r_off <= OFF_FACT_HI);
   assign r_is_user0 = (r_off >= OFF_USER_LO) && (r_off <= OFF_USER_HI);
   assign r_is_up = (r_off >= OFF_UP_LO) && (r_off <= OFF_UP_HI);
   assign r_fidx = 2'(r_off - OFF_FACT_LO);
   assign fact_word = FACTORY_UID[r_fidx*DATA_W +: DATA_W];

   // Identifier word: lock words, factory half, then user store words.
   assign id_word = (r_off == OFF_LOCK0) ? lock0_q
      : (r_off == OFF_LOCK1) ? lock1_q
      : r_is_fact ? fact_word
      : (r_is_user0 | r_is_up) ? mem_rdata
      : NOID_WORD;

   // Non-array word; page accesses past the first word are undefined.
   assign nonarray_word = ((rreq_q.mode == RDM_PAGE) && (rreq_q.pidx != '0))
      ? UNDEF_WORD
      : (rreq_q.rstate == RS_ID) ? id_word
      : {SR_HI_BYTE, sr_word};
   assign word_sel = (rreq_q.rstate == RS_ARRAY) ? array_rdata : nonarray_word;

   // Beats in a burst; async and page reads deliver one word.
   assign beats_req = (rd_mode != RDM_BURST) ? BEATS_1
      : (burst_len == 2'h0) ? BEATS_4
      : (burst_len == 2'h1) ? BEATS_8
      : BEATS_16;

   // Read request capture; store read data arrive one cycle later.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rreq_q <= '0;
         pend_q <= 1'b0;
      end else begin
         pend_q <= bus_rd;
         if (bus_rd) begin
            rreq_q.off <= bus_off;
            rreq_q.pidx <= bus_addr[PIDX_W-1:0];
            rreq_q.mode <= rd_mode;
            rreq_q.rstate <= rstate_q;
         end
      end
   end

   // Burst length bookkeeping, loaded with the request.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         beats_q <= 5'h00;
         cont_q <= 1'b0;
      end else if (bus_rd) begin
         beats_q <= beats_req;
         cont_q <= (rd_mode == RDM_BURST) && (burst_len == BL_CONT);
      end else if (burst_stop) begin
         beats_q <= 5'h00;
         cont_q <= 1'b0;
      end else if ((pend_q || rd_valid_q) && (beats_q != 5'h00) && !cont_q) begin
         beats_q <= beats_q - 5'h01;
      end
   end

   // Read data register: loaded once, then held so bursts repeat it.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rd_data_q <= NOID_WORD;
      end else if (pend_q) begin
         rd_data_q <= word_sel;
      end
   end

   // Valid stands for one beat, for the burst length, or until stop.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rd_valid_q <= 1'b0;
      end else if (burst_stop || bus_rd) begin
         rd_valid_q <= 1'b0;
      end else if (pend_q) begin
         rd_valid_q <= 1'b1;
      end else if (rd_valid_q && !cont_q && (beats_q == 5'h00)) begin
         rd_valid_q <= 1'b0;
      end
   end

   assign rd_data = rd_data_q;
   assign rd_valid = rd_valid_q;

   // Parameter block group bounds for top or bottom parts.
   assign param_hi = TOP_PARAM ? PARAM_TOP_BLK : PBOT_HI;
   assign param_lo = param_hi - PARAM_SPAN;
   assign area_hit[0] = (query_blk >= param_lo) && (query_blk <= param_hi);

   // One adjacent main block per remaining area.
   for (genvar i = 0; i < MAIN_AREAS; i++) begin : g_area
      assign area_hit[i+1] = TOP_PARAM
         ? (query_blk == BLK_W'(param_lo - BLK_W'(i + 1)))
         : (query_blk == BLK_W'(param_hi + BLK_W'(i + 1)));
   end

   // Program and erase inhibit for the queried block.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         blk_otp_q <= 1'b0;
      end else begin
         blk_otp_q <= (|(area_hit & otp_area_en)) | otp_full_en;
      end
   end

   assign blk_otp = blk_otp_q;

endmodule : osr_otp_security

//--- tb/osr_checker.sv
// Concurrent checks on the ports of the OTP security register unit.
`timescale 1ns/100ps
module osr_checker
   import osr_pkg::*;
#(
   parameter logic [BLK_W-1:0] PARAM_TOP_BLK = PTOP_256,
   parameter bit TOP_PARAM = 1'b1
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic resetn,
   // Read side.
   input wire logic bus_rd,
   input wire osr_rdm_t rd_mode,
   input wire logic [1:0] burst_len,
   input wire logic burst_stop,
   input wire logic [DATA_W-1:0] rd_data,
   input wire logic rd_valid,
   // Block query side.
   input wire logic [OTP_AREAS-1:0] otp_area_en,
   input wire logic otp_full_en,
   input wire logic [BLK_W-1:0] query_blk,
   input wire logic blk_otp
);
   logic [BLK_W-1:0] base;
   logic [BLK_W-1:0] mi;
   logic in_par;
   logic exp_otp;
   // Expected area decode: the parameter group, then three main blocks beside it.
   assign base = TOP_PARAM ? PARAM_TOP_BLK - PARAM_SPAN : 9'h000;
   assign mi = TOP_PARAM ? base - query_blk : query_blk - PARAM_SPAN;
   assign in_par = (query_blk >= base) && (query_blk <= base + PARAM_SPAN);
   assign exp_otp = otp_full_en | (otp_area_en[0] & in_par) |
      ((mi >= 9'h001) && (mi <= 9'h003) && otp_area_en[mi[1:0]]);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   property p_rd_lat;
      bus_rd ##1 !(bus_rd | burst_stop) |=> rd_valid;
   endproperty
   a_rd_lat: assert property (p_rd_lat) else $error("read data late");
   property p_rd_cause;
      $rose(rd_valid) |-> $past(bus_rd, 2);
   endproperty
   a_rd_cause: assert property (p_rd_cause) else $error("valid without request");
   property p_single;
      bus_rd && rd_mode != RDM_BURST ##1 !bus_rd [*2] |=> !rd_valid;
   endproperty
   a_single: assert property (p_single) else $error("single read too long");
   property p_same;
      rd_valid && $past(rd_valid) |-> $stable(rd_data);
   endproperty
   a_same: assert property (p_same) else $error("burst word changed");
   property p_burst4;
      bus_rd && rd_mode == RDM_BURST && burst_len == 2'h0 ##1 !(bus_rd | burst_stop) [*5]
         |-> rd_valid && $past(rd_valid, 3) ##1 !rd_valid;
   endproperty
   a_burst4: assert property (p_burst4) else $error("burst of four wrong");
   property p_stop;
      burst_stop && !$past(bus_rd) |=> !rd_valid;
   endproperty
   a_stop: assert property (p_stop) else $error("burst not stopped");
   property p_blk;
      $past(resetn) |-> blk_otp == $past(exp_otp);
   endproperty
   a_blk: assert property (p_blk) else $error("block decode wrong");
   property p_full;
      otp_full_en |=> blk_otp;
   endproperty
   a_full: assert property (p_full) else $error("full array not OTP");
endmodule : osr_checker

bind osr_otp_security osr_checker #(.PARAM_TOP_BLK(PARAM_TOP_BLK), .TOP_PARAM(TOP_PARAM)) u_chk (
   .clk(clk), .resetn(resetn), .bus_rd(bus_rd), .rd_mode(rd_mode), .burst_len(burst_len),
   .burst_stop(burst_stop), .rd_data(rd_data), .rd_valid(rd_valid),
   .otp_area_en(otp_area_en), .otp_full_en(otp_full_en), .query_blk(query_blk),
   .blk_otp(blk_otp));

//--- tb/osr_host_model.sv
// Host controller model that issues command, program and read cycles.
`timescale 1ns/100ps
module osr_host_model
   import osr_pkg::*;
#(
   parameter int ADDR_W = 24
) (
   // Clock.
   input wire logic clk,
   // Bus strobes and qualifiers.
   output logic bus_wr,
   output logic [ADDR_W-1:0] bus_addr,
   output logic [DATA_W-1:0] bus_wdata,
   output logic bus_rd,
   output osr_rdm_t rd_mode,
   output logic [1:0] burst_len,
   output logic burst_stop
);
   // Bus idle at time zero.
   initial begin
      bus_wr = 1'b0;
      bus_rd = 1'b0;
      burst_stop = 1'b0;
      bus_addr = '0;
      bus_wdata = 16'h0000;
      rd_mode = RDM_ASYNC;
      burst_len = 2'h0;
   end
   // One write cycle; released lines show the inverse so stale data never looks valid.
   task automatic wr(input logic [OFF_W-1:0] off, input logic [DATA_W-1:0] d);
      @(posedge clk);
      bus_wr <= 1'b1;
      bus_addr <= {{(ADDR_W-OFF_W){off == OFF_LOCK0}}, off};
      bus_wdata <= d;
      @(posedge clk);
      bus_wr <= 1'b0;
      bus_addr <= ~bus_addr;
      bus_wdata <= ~bus_wdata;
   endtask : wr
   // Program command and data word to one address.
   task automatic prog(input logic [OFF_W-1:0] off, input logic [DATA_W-1:0] d);
      wr(off, {8'h00, CMD_PROG_OTP});
      wr(off, d);
   endtask : prog
   // One read request with its mode and burst length.
   task automatic rd(input logic [OFF_W-1:0] off, input osr_rdm_t m, input logic [1:0] bl);
      @(posedge clk);
      bus_rd <= 1'b1;
      bus_addr <= ADDR_W'(off);
      rd_mode <= m;
      burst_len <= bl;
      @(posedge clk);
      bus_rd <= 1'b0;
      bus_addr <= ~bus_addr;
   endtask : rd
   // Pulse that ends a continuous burst.
   task automatic stop();
      @(posedge clk);
      burst_stop <= 1'b1;
      @(posedge clk);
      burst_stop <= 1'b0;
   endtask : stop
endmodule : osr_host_model

//--- tb/tb_top.sv
// Self-checking testbench of the OTP security register unit.
`timescale 1ns/100ps
module tb_top
   import osr_pkg::*;
;
   localparam logic [63:0] UID = 64'h0123456789ABCDEF; // Arbitrary value.
   logic clk = 1'b0;
   logic resetn;
   logic bus_wr, bus_rd, burst_stop, rd_valid, otp_full_en, blk_otp;
   logic [23:0] bus_addr;
   logic [15:0] bus_wdata, array_rdata, rd_data, d1, d2;
   logic [1:0] burst_len;
   logic [3:0] otp_area_en;
   logic [8:0] query_blk, off;
   osr_rdm_t rd_mode;
   logic [31:0] sd = 32'd46509;
   int fails = 0;
   int n_checks = 0;
   int k;
   // Clock of 4 ns.
   always #2 clk = ~clk;
   osr_otp_security #(.PROG_LEN(8'h08), .FACTORY_UID(UID)) u_dut (.clk(clk), .resetn(resetn),
      .bus_wr(bus_wr), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_rd(bus_rd),
      .rd_mode(rd_mode), .burst_len(burst_len), .burst_stop(burst_stop),
      .array_rdata(array_rdata), .rd_data(rd_data), .rd_valid(rd_valid),
      .otp_area_en(otp_area_en), .otp_full_en(otp_full_en), .query_blk(query_blk),
      .blk_otp(blk_otp));
   osr_host_model u_host (.clk(clk), .bus_wr(bus_wr), .bus_addr(bus_addr),
      .bus_wdata(bus_wdata), .bus_rd(bus_rd), .rd_mode(rd_mode), .burst_len(burst_len),
      .burst_stop(burst_stop));
   // Xorshift step for repeatable random values.
   function automatic logic [31:0] xs(input logic [31:0] x);
      logic [31:0] y;
      y = x ^ (x << 13);
      y = y ^ (y >> 17);
      return y ^ (y << 5);
   endfunction : xs
   // Expected OTP state of a block on a top-parameter part with top block 258.
   function automatic logic exp_blk(input logic [8:0] b, input logic [3:0] en, input logic f);
      return f | (en[0] & b >= 9'd255 & b <= 9'd258) | (en[1] & b == 9'd254) |
         (en[2] & b == 9'd253) | (en[3] & b == 9'd252);
   endfunction : exp_blk
   // Verdict and end of run.
   task automatic end_of_test();
      if (fails == 0 && n_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : end_of_test
   // Compare one value with its expectation.
   task automatic chk(input logic [15:0] s, input logic [15:0] e);
      n_checks++;
      if (s !== e) begin
         fails++;
         $display("[ERR] %0t seen %h expected %h", $time, s, e);
      end
   endtask : chk
   // Read one offset, check every beat and the number of beats; nb of 0 means continuous.
   task automatic rdc(input logic [8:0] o, input osr_rdm_t m, input logic [1:0] bl,
      input logic [15:0] e, input int nb);
      int n;
      n = 0;
      u_host.rd(o, m, bl);
      #1;
      repeat (4) if (rd_valid !== 1'b1) begin
         @(posedge clk);
         #1;
      end
      while (rd_valid === 1'b1 && n < 20) begin
         chk(rd_data, e);
         n++;
         if (nb == 0 && n == 6) u_host.stop();
         else @(posedge clk);
         #1;
      end
      chk(16'(n), 16'(nb == 0 ? 6 : nb));
   endtask : rdc
   // Reset held for 20 cycles.
   task automatic rst();
      resetn <= 1'b0;
      repeat (20) @(posedge clk);
      resetn <= 1'b1;
   endtask : rst
   // Wait out a word program.
   task automatic wt();
      repeat (14) @(posedge clk);
   endtask : wt
   // Status read with the expected flags.
   task automatic st(input logic [15:0] e);
      u_host.wr(9'h000, {8'h00, CMD_READ_STATUS});
      rdc(9'h000, RDM_ASYNC, 2'h0, e, 1);
   endtask : st
   // Enter identifier-read state.
   task automatic id();
      u_host.wr(9'h000, {8'h00, CMD_READ_ID});
   endtask : id
   // Watchdog against a hang.
   initial begin
      repeat (40000) @(posedge clk);
      fails++;
      end_of_test();
   end
   // Main sequence.
   initial begin
      resetn = 1'b0;
      array_rdata = 16'h0000;
      otp_area_en = 4'h0;
      otp_full_en = 1'b0;
      query_blk = 9'h000;
      rst();
      id();
      rdc(OFF_LOCK0, RDM_ASYNC, 2'h0, 16'hFFFE, 1);
      rdc(OFF_LOCK1, RDM_ASYNC, 2'h0, 16'hFFFF, 1);
      for (k = 0; k < 4; k++) rdc(9'h081 + 9'(k), RDM_ASYNC, 2'h0, UID[16*k+:16], 1);
      rdc(9'h085, RDM_ASYNC, 2'h0, 16'hFFFF, 1);
      rdc(9'h10A, RDM_ASYNC, 2'h0, 16'h0000, 1);
      for (k = 0; k < 4; k++) rdc(9'h081, RDM_BURST, 2'(k), UID[15:0], k == 3 ? 0 : 4 << k);
      rdc(9'h084, RDM_PAGE, 2'h0, UID[63:48], 1);
      rdc(9'h083, RDM_PAGE, 2'h0, 16'hFFFF, 1);
      st(16'h0080);
      for (k = 0; k < 6; k++) begin
         sd = xs(sd);
         off = k == 0 ? 9'h08A : k == 1 ? 9'h109 : 9'h08A + {2'h0, sd[6:0]};
         d1 = sd[31:16];
         sd = xs(sd);
         d2 = sd[15:0];
         u_host.prog(off, d1);
         wt();
         u_host.prog(off, d2);
         wt();
         id();
         rdc(off, RDM_ASYNC, 2'h0, d1 & d2, 1);
      end
      u_host.prog(9'h086, d1);
      wt();
      id();
      rdc(9'h086, RDM_ASYNC, 2'h0, d1, 1);
      rdc(9'h086, RDM_PAGE, 2'h0, 16'hFFFF, 1);
      // Re-blank the store so the locked word below is known to read blank.
      rst();
      sd = xs(sd);
      d2 = ~(16'h0001 << sd[3:0]);
      u_host.prog(OFF_LOCK1, d2);
      wt();
      u_host.prog(OFF_LOCK1, 16'hFFFF);
      wt();
      id();
      rdc(OFF_LOCK1, RDM_ASYNC, 2'h0, d2, 1);
      off = 9'h08A + {1'b0, sd[3:0], 3'h0};
      u_host.prog(off, 16'h0000);
      wt();
      st(16'h0092);
      id();
      rdc(off, RDM_ASYNC, 2'h0, 16'hFFFF, 1);
      rst();
      u_host.prog(9'h050, 16'h0000);
      wt();
      st(16'h0090);
      rst();
      u_host.prog(OFF_LOCK0, 16'hFFFD);
      wt();
      u_host.prog(9'h085, 16'h0000);
      wt();
      st(16'h0092);
      id();
      rdc(OFF_LOCK0, RDM_ASYNC, 2'h0, 16'hFFFE & 16'hFFFD, 1);
      rdc(9'h085, RDM_ASYNC, 2'h0, 16'hFFFF, 1);
      u_host.wr(9'h000, {8'h00, CMD_READ_ARRAY});
      sd = xs(sd);
      @(posedge clk) array_rdata <= sd[15:0];
      rdc(9'h000, RDM_ASYNC, 2'h0, sd[15:0], 1);
      for (k = 0; k < 200; k++) begin
         sd = xs(sd);
         @(posedge clk);
         query_blk <= 9'd248 + {5'h00, sd[3:0]};
         otp_area_en <= sd[7:4];
         otp_full_en <= sd[10:8] == 3'h0;
         @(posedge clk);
         #1;
         chk({15'h0000, blk_otp}, {15'h0000, exp_blk(query_blk, otp_area_en, otp_full_en)});
      end
      end_of_test();
   end
endmodule : tb_top
